//--- hdl/cid_decoder.sv
// Purpose: custom instruction decoder and execute unit beside the core
// Assumes: core request and response on sys_clk; avalon-mm control slave
// Notes: destination decode combinational; results leave from flops
`timescale 1ns/1ps
module cid_decoder
  import cid_pkg::*;
#(
  parameter bit HAS_CUSTOM = 1'b1,
  parameter int MUL_WIDTH = DATA_W
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  input wire cid_core_req_t coreReq,
  output cid_core_rsp_t coreRsp
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
    input logic [31:0] wdata, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[8*i +: 8] = wdata[8*i +: 8];
    return res;
  endfunction

  function automatic logic [31:0] execOp(input logic [3:0] op,
    input logic [31:0] a, input logic [31:0] b, input logic [4:0] imm,
    input logic [31:0] intv, input logic [31:0] prod);
    logic [63:0] rot;
    logic [31:0] res;
    rot = {a, a} >> imm;
    case (op)
      OP_ADD: res = a + b;
      OP_SUB: res = a - b;
      OP_XOR: res = a ^ b;
      OP_MINU: res = (a < b) ? a : b;
      OP_ROTR: res = rot[31:0];
      OP_MUL: res = prod;
      OP_ACC: res = intv + a + b;
      OP_MFI: res = intv;
      default: res = WORD_RESET;
    endcase
    return res;
  endfunction

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  cid_decode_t dec;
  logic [1:0] ctrl_r;
  logic [15:0] implMask_r;
  logic [31:0] execCount_r;
  logic [31:0] intReg_r [INT_REGS];
  logic pendValid_r;
  logic [1:0] pendIdx_r;
  logic [31:0] pendData_r;
  logic [31:0] result_r;
  logic resultValid_r;
  logic ack_r;
  logic [31:0] readData_r;
  logic busReq;
  logic wrFire;
  logic rdLoad;
  logic intSel;
  logic [1:0] busIdx;
  logic commitNow;
  logic exeOn;
  logic implemented;
  logic runOk;
  logic reservedE;
  logic stallE;
  logic takeE;
  logic mulStart;
  logic mulHold;
  logic mulBusy;
  logic mulDone;
  logic [MUL_WIDTH-1:0] mulProd;
  logic [31:0] mulWord;
  logic [31:0] intCur;
  logic [31:0] opValue;
  logic [15:0] effMask;
  logic [31:0] statusWord;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  // whole word decoded locally
  cid_field_decode u_decode (
    .insn(coreReq.insn),
    .isaCompact(coreReq.isaCompact),
    .dec(dec)
  );

  assign effMask = BUILT_OPS & implMask_r;

  // custom only on matching major opcode
  assign exeOn = HAS_CUSTOM && coreReq.insnValid && dec.isCustom;
  assign implemented = dec.opValid && effMask[dec.op] && ctrl_r[CTRL_EXEC_BIT];
  assign runOk = exeOn && implemented;
  assign reservedE = exeOn && !implemented;
  assign stallE = runOk && dec.multiCycle && !mulDone;
  assign takeE = runOk && coreReq.advance && !stallE;

  // ----------------------------------------
  // multi-cycle unit
  // ----------------------------------------
  // private multiplier, core pair untouched
  assign mulHold = runOk && dec.multiCycle;
  assign mulStart = mulHold && !mulBusy && !mulDone;

  cid_iter_mul #(
    .WIDTH(MUL_WIDTH)
  ) u_mul (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(mulStart),
    .hold(mulHold),
    .ack(coreReq.advance),
    .multiplicand(MUL_WIDTH'(coreReq.srcA)),
    .multiplier(MUL_WIDTH'(coreReq.srcB)),
    .busy(mulBusy),
    .done(mulDone),
    .product(mulProd)
  );

  // product cut or padded to a word on purpose
  assign mulWord = 32'(mulProd);

  // ----------------------------------------
  // execute
  // ----------------------------------------
  // uncommitted result forwarded to a following read of the same entry
  assign intCur = (pendValid_r && pendIdx_r == dec.intIdx) ? pendData_r
    : intReg_r[dec.intIdx];
  // operands and immediate from fixed fields
  assign opValue = execOp(dec.op, coreReq.srcA, coreReq.srcB, dec.imm,
    intCur, mulWord);

  // result leaves from a flop as the instruction moves on
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      result_r <= WORD_RESET;
      resultValid_r <= 1'b0;
    end
    else
    begin
      resultValid_r <= takeE && dec.gprWrite;
      if (takeE && dec.gprWrite)
        result_r <= opValue;
    end
  end

  // ----------------------------------------
  // internal registers
  // ----------------------------------------
  // internal result waits for the core's commit
  assign commitNow = pendValid_r && coreReq.commitM && !coreReq.killM;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pendValid_r <= 1'b0;
      pendIdx_r <= 2'h0;
      pendData_r <= WORD_RESET;
    end
    // only taken custom words load the pending slot
    else if (takeE && dec.intWrite)
    begin
      pendValid_r <= 1'b1;
      pendIdx_r <= dec.intIdx;
      pendData_r <= opValue;
    end
    else if (commitNow || coreReq.killM)
      pendValid_r <= 1'b0;
  end

  // core commit wins over a bus write to the same entry
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < INT_REGS; i++)
        intReg_r[i] <= WORD_RESET;
    end
    else
    begin
      for (int i = 0; i < INT_REGS; i++)
      begin
        if (commitNow && pendIdx_r == 2'(i))
          intReg_r[i] <= pendData_r;
        else if (wrFire && intSel && busIdx == 2'(i))
          intReg_r[i] <= mergeBytes(intReg_r[i], avsWriteData, avsByteEnable);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      execCount_r <= WORD_RESET;
    else if (takeE)
      execCount_r <= execCount_r + 32'h00000001;
  end

  // ----------------------------------------
  // core response
  // ----------------------------------------
  always_comb
  begin
    coreRsp = '0;
    if (HAS_CUSTOM)
    begin
      coreRsp.destReg = (runOk && dec.gprWrite) ? dec.dest : ZERO_REGISTER;
      coreRsp.stall = stallE;
      // reserved and honour-enable are the only fault sources
      coreRsp.reservedInsn = reservedE;
      coreRsp.honourEnable = ctrl_r[CTRL_HONOUR_BIT];
      // presence reported for the configuration bit
      coreRsp.present = 1'b1;
      coreRsp.result = result_r;
      coreRsp.resultValid = resultValid_r;
    end
    else
    begin
      coreRsp.reservedInsn = 1'b1;
    end
  end

  // ----------------------------------------
  // avalon slave, one wait state
  // ----------------------------------------
  assign busReq = avsRead || avsWrite;
  assign avsWaitrequest = busReq && !ack_r;
  assign wrFire = avsWrite && ack_r;
  assign rdLoad = avsRead && !ack_r;
  assign intSel = avsAddress[INTREG_SEL_BIT];
  assign busIdx = avsAddress[3:2];
  assign avsReadData = readData_r;

  always_comb
  begin
    statusWord = WORD_RESET;
    statusWord[STAT_BUSY_BIT] = mulBusy;
    statusWord[STAT_PEND_BIT] = pendValid_r;
    statusWord[STAT_PRESENT_BIT] = HAS_CUSTOM;
  end

  // ack toggles so back-to-back requests each get a wait state
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      ack_r <= 1'b0;
    else
      ack_r <= busReq && !ack_r;
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      readData_r <= WORD_RESET;
    else if (rdLoad)
    begin
      if (intSel)
        readData_r <= intReg_r[busIdx];
      else
        case (avsAddress)
          ADDR_CTRL: readData_r <= {30'h00000000, ctrl_r};
          ADDR_IMPL: readData_r <= {16'h0000, implMask_r};
          ADDR_STATUS: readData_r <= statusWord;
          ADDR_COUNT: readData_r <= execCount_r;
          default: readData_r <= WORD_RESET;
        endcase
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_RESET;
      implMask_r <= IMPL_RESET;
    end
    else if (wrFire && !intSel)
    begin
      if (avsAddress == ADDR_CTRL && avsByteEnable[0])
        ctrl_r <= avsWriteData[1:0];
      if (avsAddress == ADDR_IMPL)
      begin
        if (avsByteEnable[0])
          implMask_r[7:0] <= avsWriteData[7:0];
        if (avsByteEnable[1])
          implMask_r[15:8] <= avsWriteData[15:8];
      end
    end
  end
endmodule // cid_decoder

//--- hdl/cid_field_decode.sv
// Purpose: combinational field decode of one instruction word
// Assumes: full word from the core, isa select stable with it
// Notes: no state; destination decode feeds the core the same cycle
`timescale 1ns/1ps
module cid_field_decode
  import cid_pkg::*;
(
  input wire logic [31:0] insn,
  input wire logic isaCompact,
  output cid_decode_t dec
);
  logic baseHit;
  logic cmpHit;

  always_comb
  begin
    dec = '0;
    // function bits 5:4 qualify the group
    baseHit = (insn[MAJOR_MSB:MAJOR_LSB] == SPECIAL_GROUP_OPCODE)
      && (insn[FUNC_HI_MSB:FUNC_HI_LSB] == BASE_FUNC_HI);
    // minor bits 2:0 qualify compact words
    cmpHit = (insn[MAJOR_MSB:MAJOR_LSB] == COMPACT_MAJOR_OPCODE_POOL)
      && (insn[CMP_MINOR_MSB:CMP_MINOR_LSB] == COMPACT_MINOR);
    if (isaCompact)
    begin
      dec.isCustom = cmpHit;
      dec.op = {1'b0, insn[CMP_OP_MSB:CMP_OP_LSB]};
      dec.opValid = insn[CMP_OP_MSB:CMP_OP_LSB] <= COMPACT_OP_LAST;
    end
    else
    begin
      dec.isCustom = baseHit;
      dec.op = insn[BASE_OP_MSB:BASE_OP_LSB];
      dec.opValid = 1'b1;
    end
    dec.imm = insn[IMM_MSB:IMM_LSB];
    dec.intIdx = insn[IDX_MSB:IDX_LSB];
    case (dec.op)
      // destination field below the second source
      OP_ADD, OP_SUB, OP_XOR, OP_MINU, OP_ROTR:
      begin
        dec.gprWrite = 1'b1;
        dec.dest = insn[DEST_MSB:DEST_LSB];
      end
      OP_MUL:
      begin
        dec.gprWrite = 1'b1;
        dec.multiCycle = 1'b1;
        dec.dest = insn[DEST_MSB:DEST_LSB];
      end
      OP_MFI:
      begin
        dec.gprWrite = 1'b1;
        dec.dest = insn[SRC2_MSB:SRC2_LSB];
      end
      OP_ACC, OP_CLRI:
      begin
        dec.intWrite = 1'b1;
        dec.dest = ZERO_REGISTER;
      end
      default:
      begin
        dec.dest = ZERO_REGISTER;
      end
    endcase
  end
endmodule // cid_field_decode

//--- hdl/cid_iter_mul.sv
// Purpose: iterative shift-add multiplier, one bit per cycle
// Assumes: operands held by the core while the unit runs
// Notes: low word of the product only; own result, no shared state
`timescale 1ns/1ps
module cid_iter_mul
  import cid_pkg::*;
#(
  parameter int WIDTH = DATA_W
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic hold,
  input wire logic ack,
  input wire logic [WIDTH-1:0] multiplicand,
  input wire logic [WIDTH-1:0] multiplier,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] product
);
  localparam int CNT_W = $clog2(WIDTH);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WIDTH - 1);

  cid_mstate_t state_r;
  logic [CNT_W-1:0] count_r;
  logic [WIDTH-1:0] mcand_r;
  logic [WIDTH-1:0] mplier_r;
  logic [WIDTH-1:0] acc_r;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      state_r <= MS_IDLE;
    else
      case (state_r)
        MS_IDLE: if (start) state_r <= MS_RUN;
        MS_RUN:
        begin
          if (!hold)
            state_r <= MS_IDLE;
          else if (count_r == CNT_LAST)
            state_r <= MS_DONE;
        end
        MS_DONE: if (ack || !hold) state_r <= MS_IDLE;
        default: state_r <= MS_IDLE;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      count_r <= '0;
      mcand_r <= '0;
      mplier_r <= '0;
      acc_r <= '0;
    end
    else if (state_r == MS_IDLE && start)
    begin
      count_r <= '0;
      mcand_r <= multiplicand;
      mplier_r <= multiplier;
      acc_r <= '0;
    end
    else if (state_r == MS_RUN)
    begin
      if (mplier_r[0])
        acc_r <= acc_r + mcand_r;
      mcand_r <= mcand_r << 1;
      mplier_r <= mplier_r >> 1;
      count_r <= count_r + 1'b1;
    end
  end

  assign busy = (state_r == MS_RUN);
  assign done = (state_r == MS_DONE);
  assign product = acc_r;
endmodule // cid_iter_mul

//--- hdl/cid_pkg.sv
// Purpose: shared constants and types for the custom instruction decoder
// Assumes: 32-bit instruction words, 32-bit avalon data, word registers
// Notes: major, source, destination and immediate positions serve both encodings; op fields differ
package cid_pkg;
  // ----------------------------------------
  // instruction encoding
  // ----------------------------------------
  localparam int DATA_W = 32;
  localparam int MAJOR_MSB = 31;
  localparam int MAJOR_LSB = 26;
  localparam int SRC1_MSB = 25;
  localparam int SRC1_LSB = 21;
  localparam int SRC2_MSB = 20;
  localparam int SRC2_LSB = 16;
  localparam int DEST_MSB = 15;
  localparam int DEST_LSB = 11;
  localparam int IMM_MSB = 10;
  localparam int IMM_LSB = 6;
  localparam int IDX_MSB = 7;
  localparam int IDX_LSB = 6;
  localparam int FUNC_HI_MSB = 5;
  localparam int FUNC_HI_LSB = 4;
  localparam int BASE_OP_MSB = 3;
  localparam int BASE_OP_LSB = 0;
  localparam int CMP_OP_MSB = 5;
  localparam int CMP_OP_LSB = 3;
  localparam int CMP_MINOR_MSB = 2;
  localparam int CMP_MINOR_LSB = 0;
  localparam logic [5:0] SPECIAL_GROUP_OPCODE = 6'h1C;
  localparam logic [5:0] COMPACT_MAJOR_OPCODE_POOL = 6'h00;
  localparam logic [1:0] BASE_FUNC_HI = 2'h1;
  localparam logic [2:0] COMPACT_MINOR = 3'h3;
  localparam logic [2:0] COMPACT_OP_LAST = 3'h6;
  localparam logic [4:0] ZERO_REGISTER = 5'h00;
  localparam int INT_REGS = 4;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_IMPL = 5'h04;
  localparam logic [4:0] ADDR_STATUS = 5'h08;
  localparam logic [4:0] ADDR_COUNT = 5'h0C;
  localparam int INTREG_SEL_BIT = 4;
  localparam int CTRL_HONOUR_BIT = 0;
  localparam int CTRL_EXEC_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam logic [15:0] IMPL_RESET = 16'hFFFF;
  localparam logic [15:0] BUILT_OPS = 16'h01FF;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_PRESENT_BIT = 2;
  localparam logic [31:0] WORD_RESET = 32'h00000000;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_XOR = 4'h2,
    OP_MINU = 4'h3,
    OP_ROTR = 4'h4,
    OP_MUL = 4'h5,
    OP_ACC = 4'h6,
    OP_MFI = 4'h7,
    OP_CLRI = 4'h8
  } cid_op_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_RUN = 2'b01,
    MS_DONE = 2'b10
  } cid_mstate_t;

  typedef struct packed {
    logic [31:0] insn;
    logic insnValid;
    logic isaCompact;
    logic [31:0] srcA;
    logic [31:0] srcB;
    logic advance;
    logic commitM;
    logic killM;
  } cid_core_req_t;

  typedef struct packed {
    logic [4:0] destReg;
    logic stall;
    logic reservedInsn;
    logic honourEnable;
    logic present;
    logic [31:0] result;
    logic resultValid;
  } cid_core_rsp_t;

  typedef struct packed {
    logic isCustom;
    logic opValid;
    logic [3:0] op;
    logic [4:0] dest;
    logic [4:0] imm;
    logic [1:0] intIdx;
    logic gprWrite;
    logic intWrite;
    logic multiCycle;
  } cid_decode_t;
endpackage

//--- sim/cid_core_model.sv
// Purpose: execute-stage model of the core
// Assumes: one instruction in flight, stall honoured
// Notes: released fields show inverted values
`timescale 1ns/1ps
module cid_core_model
  import cid_pkg::*;
(
  input wire logic sys_clk,
  input wire cid_core_rsp_t coreRsp,
  output cid_core_req_t coreReq
);
  logic ceeSet = 1'b0;
  logic stl, seenRsv, seenUnusable, seenResV;
  logic [4:0] seenDest;
  logic [31:0] seenRes, cfgWord;
  int stalls;
  assign cfgWord = {9'h000, coreRsp.present, 22'h000000};
  initial coreReq = '0;
  task automatic issue(input logic [31:0] w, input logic cmp, input logic [31:0] a,
    input logic [31:0] b, input logic kill);
    // single issue, so source fields never interlock here
    @(posedge sys_clk);
    coreReq <= '{w, 1'b1, cmp, a, b, 1'b1, 1'b0, 1'b0};
    for (stalls = 0; stalls < 40; stalls++)
    begin
      @(posedge sys_clk);
      stl = coreRsp.stall;
      seenDest = coreRsp.destReg;
      seenRsv = coreRsp.reservedInsn;
      seenUnusable = coreRsp.honourEnable && !ceeSet;
      if (!stl)
        break;
    end
    if (stl)
    begin
      cid_decoder_tb.nFail++;
      cid_decoder_tb.report_and_stop();
    end
    // valid dropped, fields inverted, M stage commit or kill
    coreReq <= '{~w, 1'b0, cmp, ~a, ~b, 1'b0, !kill, kill};
    @(posedge sys_clk);
    seenResV = coreRsp.resultValid;
    seenRes = coreRsp.result;
    coreReq.commitM <= 1'b0;
    coreReq.killM <= 1'b0;
  endtask
endmodule // cid_core_model

//--- sim/cid_decoder_checker.sv
// Purpose: port assertions for the decoder
// Assumes: one clock, synchronous active-low reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
module cid_decoder_checker
  import cid_pkg::*;
#(
  parameter bit HAS_CUSTOM = 1'b1,
  parameter int MUL_WIDTH = DATA_W
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitrequest,
  input wire cid_core_req_t coreReq,
  input wire cid_core_rsp_t coreRsp
);
  logic [31:0] w;
  logic [3:0] op;
  logic [4:0] expDest;
  logic [7:0] run_r;
  logic cust, ok, gpr, take, busReq;
  assign w = coreReq.insn;
  assign op = coreReq.isaCompact ? {1'b0, w[5:3]} : w[3:0];
  assign cust = coreReq.insnValid && (coreReq.isaCompact
    ? (w[31:26] == COMPACT_MAJOR_OPCODE_POOL && w[2:0] == COMPACT_MINOR)
    : (w[31:26] == SPECIAL_GROUP_OPCODE && w[5:4] == BASE_FUNC_HI));
  assign ok = cust && !coreRsp.reservedInsn;
  assign gpr = ok && (op <= OP_MUL || op == OP_MFI);
  assign expDest = op == OP_MFI ? w[20:16] : (gpr ? w[15:11] : ZERO_REGISTER);
  assign take = gpr && coreReq.advance && !coreRsp.stall;
  assign busReq = avsRead || avsWrite;
  // ----
  // stall run length
  // ----
  always_ff @(posedge sys_clk)
  begin
    if (!rstn || !coreRsp.stall)
      run_r <= 8'h00;
    else
      run_r <= run_r + 8'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_foreign_quiet: assert property (HAS_CUSTOM &&
    coreReq.insnValid && !cust |->
    coreRsp.destReg == ZERO_REGISTER && !coreRsp.stall && !coreRsp.reservedInsn)
    else $error("foreign word not ignored");
  a_invalid_quiet: assert property (HAS_CUSTOM && !coreReq.insnValid |->
    {coreRsp.destReg, coreRsp.stall, coreRsp.reservedInsn} == 7'h00)
    else $error("invalid word not ignored");
  a_dest_field: assert property (ok |-> coreRsp.destReg == expDest)
    else $error("destination index wrong");
  a_unimpl_flag: assert property (cust && (coreReq.isaCompact ?
    w[5:3] > COMPACT_OP_LAST : w[3:0] > OP_CLRI) |-> coreRsp.reservedInsn)
    else $error("unimplemented opcode not flagged");
  a_present_level: assert property (coreRsp.present == HAS_CUSTOM)
    else $error("presence output wrong");
  a_empty_build: assert property (!HAS_CUSTOM |-> coreRsp.reservedInsn &&
    {coreRsp.destReg, coreRsp.stall, coreRsp.honourEnable, coreRsp.present, coreRsp.result,
    coreRsp.resultValid} == 41'h0)
    else $error("empty build outputs wrong");
  a_stall_cause: assert property (coreRsp.stall |-> ok && op == OP_MUL)
    else $error("stall without multi-cycle op");
  a_stall_bound: assert property (coreRsp.stall |-> run_r < MUL_WIDTH + 1)
    else $error("stall too long");
  a_stall_full: assert property ($fell(coreRsp.stall) && coreReq.insnValid |->
    run_r == MUL_WIDTH + 1)
    else $error("stall too short");
  a_take_result: assert property (take |=> coreRsp.resultValid)
    else $error("no result after take");
  a_result_cause: assert property (coreRsp.resultValid |-> $past(take))
    else $error("result without instruction");
  a_add_sum: assert property (take && op == OP_ADD |=>
    coreRsp.result == $past(coreReq.srcA) + $past(coreReq.srcB))
    else $error("sum wrong");
  a_wait_once: assert property ($rose(busReq) |-> avsWaitrequest ##1 !avsWaitrequest)
    else $error("wait state count wrong");
  c_mul_run: cover property (run_r == 8'h10);
  c_acc_take: cover property (ok && op == OP_ACC && coreReq.advance);
  c_bus_read: cover property (avsRead && !avsWaitrequest);
endmodule // cid_decoder_checker

bind cid_decoder cid_decoder_checker #(.HAS_CUSTOM(HAS_CUSTOM), .MUL_WIDTH(MUL_WIDTH)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
  .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest), .coreReq(coreReq),
  .coreRsp(coreRsp));

//--- sim/cid_decoder_tb.sv
// Purpose: self-checking bench for the decoder
// Assumes: core model drives requests, bench drives avalon
// Notes: full-width multiply
`timescale 1ns/1ps
module cid_decoder_tb
  import cid_pkg::*;
;
  localparam int MULW = 32;
  logic sys_clk, rstn, avsRead, avsWrite, avsWaitrequest;
  logic [4:0] avsAddress;
  logic [3:0] avsByteEnable;
  logic [31:0] avsWriteData, avsReadData, r;
  cid_core_req_t coreReq;
  cid_core_rsp_t coreRsp;
  cid_core_rsp_t emptyRsp;
  int nFail = 0;
  int nChecks = 0;
  cid_decoder #(.HAS_CUSTOM(1'b1), .MUL_WIDTH(MULW)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest), .coreReq(coreReq), .coreRsp(coreRsp));
  cid_decoder #(.HAS_CUSTOM(1'b0), .MUL_WIDTH(MULW)) dut_empty (.sys_clk(sys_clk),
    .rstn(rstn), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(),
    .avsWaitrequest(), .coreReq(coreReq), .coreRsp(emptyRsp));
  cid_core_model core (.sys_clk(sys_clk), .coreRsp(coreRsp), .coreReq(coreReq));
  always #50 sys_clk = ~sys_clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    for (int i = 0; i < 21; i++)
    begin
      if (i == 20)
      begin
        nFail++;
        report_and_stop();
      end
      @(posedge sys_clk);
      if (!avsWaitrequest)
        break;
    end
    r = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h00000000);
    chk(what, r, exp);
  endtask
  function automatic logic [31:0] bw(input logic [3:0] op, input logic [4:0] t, d, m);
    return {SPECIAL_GROUP_OPCODE, 5'h03, t, d, m, BASE_FUNC_HI, op};
  endfunction
  function automatic logic [31:0] cw(input logic [2:0] op, input logic [4:0] t, d, m);
    return {COMPACT_MAJOR_OPCODE_POOL, 5'h03, t, d, m, op, COMPACT_MINOR};
  endfunction
  function automatic logic [31:0] alu(input logic [3:0] k, input logic [31:0] a, b);
    case (k)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return a ^ b;
      4'h3: return a < b ? a : b;
      default: return {a[4:0], a[31:5]};
    endcase
  endfunction
  task automatic t_regs();
    rdchk(ADDR_CTRL, {30'h0, CTRL_RESET}, "ctrl");
    rdchk(ADDR_IMPL, {16'h0000, IMPL_RESET}, "impl");
    rdchk(ADDR_STATUS, 32'h00000004, "status");
    bus(1'b1, ADDR_COUNT, 32'h000000FF);
    rdchk(ADDR_COUNT, 32'h00000000, "count");
    rdchk(5'h02, 32'h00000000, "unmapped");
    chk("cfg", core.cfgWord[22], 1'b1);
    chk("empty", {emptyRsp.reservedInsn, emptyRsp.present, emptyRsp.destReg}, 32'h00000040);
  endtask
  task automatic t_ops();
    logic [3:0] op;
    logic cmp;
    for (int k = 0; k < 10; k++)
    begin
      cmp = k > 4;
      op = 4'(k % 5);
      core.issue(cmp ? cw(op[2:0], 5'h04, 5'h09, 5'h05) : bw(op, 5'h04, 5'h09, 5'h05), cmp,
        32'h80000013, 32'h00000F21, 1'b0);
      chk("dest", core.seenDest, 5'h09);
      chk("res", core.seenRes, alu(op, 32'h80000013, 32'h00000F21));
      chk("stall", core.stalls, 0);
    end
  endtask
  task automatic t_mul();
    core.issue(bw(OP_MUL, 5'h04, 5'h0A, 5'h00), 1'b0, 32'h00012345, 32'h00000321, 1'b0);
    chk("mulstall", core.stalls, MULW + 1);
    chk("mulres", core.seenRes, 32'h00012345 * 32'h00000321);
    chk("muldest", core.seenDest, 5'h0A);
  endtask
  task automatic t_reject();
    logic [31:0] mb [4] = '{32'h04000000, 32'h00000010, 32'h00000020, 32'h00000000};
    logic [31:0] mc [4] = '{32'h04000000, 32'h00000001, 32'h00000002, 32'h00000000};
    for (int i = 0; i < 8; i++)
    begin
      core.issue(i[0] ? cw(3'h6, 5'h04, 5'h00, 5'h01) ^ mc[i / 2]
        : bw(OP_ACC, 5'h04, 5'h00, 5'h01) ^ mb[i / 2], i[0] ^ (i > 5), 32'h5, 32'h7, 1'b0);
      chk("rjdest", core.seenDest, 5'h00);
      chk("rjrsv", core.seenRsv, 1'b0);
      chk("rjres", core.seenResV, 1'b0);
    end
    rdchk(5'h14, 32'h00000000, "rjint");
  endtask
  task automatic t_unimpl();
    for (int k = 9; k < 17; k++)
    begin
      core.issue(k < 16 ? bw(4'(k), 5'h04, 5'h09, 5'h05) : cw(3'h7, 5'h04, 5'h09, 5'h05),
        k == 16, 32'h1, 32'h2, 1'b0);
      chk("rsv", core.seenRsv, 1'b1);
    end
    bus(1'b1, ADDR_IMPL, 32'h0000FFFE);
    core.issue(bw(OP_ADD, 5'h04, 5'h09, 5'h05), 1'b0, 32'h1, 32'h2, 1'b0);
    chk("maskrsv", core.seenRsv, 1'b1);
    bus(1'b1, ADDR_IMPL, 32'h0000FFFF);
    bus(1'b1, ADDR_CTRL, 32'h00000001);
    core.issue(bw(OP_ADD, 5'h04, 5'h09, 5'h05), 1'b0, 32'h1, 32'h2, 1'b0);
    chk("offrsv", core.seenRsv, 1'b1);
    chk("unusable", core.seenUnusable, 1'b1);
    bus(1'b1, ADDR_CTRL, 32'h00000002);
    core.issue(bw(OP_ADD, 5'h04, 5'h09, 5'h05), 1'b0, 32'h1, 32'h2, 1'b0);
    chk("onrsv", core.seenRsv, 1'b0);
    chk("usable", core.seenUnusable, 1'b0);
  endtask
  task automatic t_internal();
    core.issue(bw(OP_ACC, 5'h04, 5'h1F, 5'h01), 1'b0, 32'h5, 32'h7, 1'b0);
    chk("accdest", core.seenDest, 5'h00);
    chk("accstall", core.stalls, 0);
    core.issue(bw(OP_ACC, 5'h04, 5'h1F, 5'h01), 1'b0, 32'h1, 32'h1, 1'b1);
    rdchk(5'h14, 32'h0000000C, "acc");
    core.issue(bw(OP_MFI, 5'h06, 5'h1F, 5'h01), 1'b0, 32'h0, 32'h0, 1'b0);
    chk("mfidest", core.seenDest, 5'h06);
    chk("mfires", core.seenRes, 32'h0000000C);
    bus(1'b1, 5'h18, 32'h000000A5);
    rdchk(5'h18, 32'h000000A5, "intwr");
    core.issue(bw(OP_CLRI, 5'h04, 5'h00, 5'h01), 1'b0, 32'h0, 32'h0, 1'b0);
    rdchk(5'h14, 32'h00000000, "clr");
  endtask
  initial
  begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    avsAddress = 5'h00;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWriteData = 32'h00000000;
    avsByteEnable = 4'hF;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_ops();
    t_mul();
    t_reject();
    t_unimpl();
    t_internal();
    report_and_stop();
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    nFail++;
    report_and_stop();
  end
endmodule // cid_decoder_tb
